// ===== rtl/cswt_params.svh
// How it works
// - fail-safe turns timer switches off, static sensing
// - switch faults in active modes disable switch
// - timers keep running after fault shutdown
// - cyclic sense wake sets input's wake flag
// - stop gives interrupt, sleep gives restart
// - sleep with set flags restarts at once
// - wake-source timer interrupts in normal, stop
// - active on-time write starts the timer
// - cyclic wake skips first on-time start
// - each switch maps to either timer
// - seven selectable periods, 10 ms to 2 s
// - five on-times or static low/high
// - change against previous sample is wake
// - sample filtered after on-time, must stay
// - on-time longer than period flags failure
`ifndef CSWT_PARAMS_SVH
`define CSWT_PARAMS_SVH
// ==========================================================
// timing
`define CSWT_CLK_NS      8
`define CSWT_TICK_NS     10000
`define CSWT_TICK_US     10
`define CSWT_FILT_NS     16000
// periods in microseconds, select codes 0..6
`define CSWT_PER0_US     10000
`define CSWT_PER1_US     20000
`define CSWT_PER2_US     50000
`define CSWT_PER3_US     100000
`define CSWT_PER4_US     200000
`define CSWT_PER5_US     1000000
`define CSWT_PER6_US     2000000
// on-times in microseconds, select codes 0..4
`define CSWT_ON0_US      100
`define CSWT_ON1_US      300
`define CSWT_ON2_US      1000
`define CSWT_ON3_US      10000
`define CSWT_ON4_US      20000
// ==========================================================
// encodings
`define CSWT_ON_OFF_LOW  3'h5
`define CSWT_ON_OFF_HIGH 3'h6
`define CSWT_MAP_OFF     2'h0
`define CSWT_MAP_ON      2'h1
`define CSWT_MAP_T1      2'h2
`define CSWT_MAP_T2      2'h3
`define CSWT_SNS_STATIC  2'h0
`define CSWT_SNS_T1      2'h1
`define CSWT_SNS_T2      2'h2
`endif

// ===== rtl/cswt_pkg.sv
`include "cswt_params.svh"
package cswt_pkg;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      CSWT_NORMAL   = 3'h0,
      CSWT_STOP     = 3'h1,
      CSWT_RESTART  = 3'h2,
      CSWT_SLEEP    = 3'h3,
      CSWT_FAILSAFE = 3'h7,
      CSWT_INIT     = 3'h5
   } cswt_mode_e;
   typedef struct packed {
      logic [2:0] per_sel;
      logic [2:0] on_sel;
   } cswt_tmr_cfg_s;
   typedef struct packed {
      logic oc;
      logic ot;
      logic uv_ov;
   } cswt_hs_fault_s;
   typedef logic [17:0] cswt_tick_t;

   // ==========================================================
   // period select to 10 us ticks
   function automatic cswt_tick_t cswt_per_ticks(input logic [2:0] s);
      case (s)
         3'h0:    return 18'(`CSWT_PER0_US / `CSWT_TICK_US);
         3'h1:    return 18'(`CSWT_PER1_US / `CSWT_TICK_US);
         3'h2:    return 18'(`CSWT_PER2_US / `CSWT_TICK_US);
         3'h3:    return 18'(`CSWT_PER3_US / `CSWT_TICK_US);
         3'h4:    return 18'(`CSWT_PER4_US / `CSWT_TICK_US);
         3'h5:    return 18'(`CSWT_PER5_US / `CSWT_TICK_US);
         default: return 18'(`CSWT_PER6_US / `CSWT_TICK_US);
      endcase
   endfunction : cswt_per_ticks

   // on-time select to ticks, zero for off settings
   function automatic cswt_tick_t cswt_on_ticks(input logic [2:0] s);
      case (s)
         3'h0:    return 18'(`CSWT_ON0_US / `CSWT_TICK_US);
         3'h1:    return 18'(`CSWT_ON1_US / `CSWT_TICK_US);
         3'h2:    return 18'(`CSWT_ON2_US / `CSWT_TICK_US);
         3'h3:    return 18'(`CSWT_ON3_US / `CSWT_TICK_US);
         3'h4:    return 18'(`CSWT_ON4_US / `CSWT_TICK_US);
         default: return 18'h0_0000;
      endcase
   endfunction : cswt_on_ticks

   function automatic logic cswt_on_active(input logic [2:0] s);
      return s < `CSWT_ON_OFF_LOW;
   endfunction : cswt_on_active
endpackage : cswt_pkg

// ===== rtl/cswt_timer.sv
`timescale 1ns/1ns
`include "cswt_params.svh"
module cswt_timer (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // timebase and configuration
   input  wire logic                   tick,
   input  wire logic                   cfg_wr,
   input  wire cswt_pkg::cswt_tmr_cfg_s cfg,
   // timer state
   output logic                        run,
   output logic                        level,
   output logic                        on_start,
   output logic                        on_end,
   output logic                        first
);
   import cswt_pkg::*;

   cswt_tmr_cfg_s cfg_reg,   cfg_next;
   cswt_tick_t    cnt_reg,   cnt_next;
   logic          run_reg,   run_next;
   logic          first_reg, first_next;
   logic          start_reg, start_next;
   logic          end_reg,   end_next;
   logic          lvl_reg,   lvl_next;

   // ==========================================================
   // period and on-time sequencing
   always_comb begin
      cfg_next   = cfg_reg;
      cnt_next   = cnt_reg;
      run_next   = run_reg;
      first_next = first_reg;
      start_next = 1'b0;
      end_next   = 1'b0;
      if (cfg_wr) begin
         cfg_next = cfg;
         cnt_next = 18'h0_0000;
         if (cswt_on_active(cfg.on_sel)) begin
            run_next   = 1'b1;
            first_next = 1'b1;
            start_next = 1'b1;
         end else begin
            run_next = 1'b0;
         end
      end else if (run_reg && tick) begin
         if (cnt_reg == cswt_per_ticks(cfg_reg.per_sel) - 18'h0_0001) begin
            cnt_next   = 18'h0_0000;
            start_next = 1'b1;
            first_next = 1'b0;
         end else begin
            cnt_next = cnt_reg + 18'h0_0001;
            end_next = (cnt_next == cswt_on_ticks(cfg_reg.on_sel));
         end
      end
      if (run_next)
         lvl_next = cnt_next < cswt_on_ticks(cfg_next.on_sel);
      else
         lvl_next = (cfg_next.on_sel == `CSWT_ON_OFF_HIGH);
   end

   // register stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg   <= '{per_sel: 3'h0, on_sel: `CSWT_ON_OFF_LOW};
         cnt_reg   <= 18'h0_0000;
         run_reg   <= 1'b0;
         first_reg <= 1'b0;
         start_reg <= 1'b0;
         end_reg   <= 1'b0;
         lvl_reg   <= 1'b0;
      end else begin
         cfg_reg   <= cfg_next;
         cnt_reg   <= cnt_next;
         run_reg   <= run_next;
         first_reg <= first_next;
         start_reg <= start_next;
         end_reg   <= end_next;
         lvl_reg   <= lvl_next;
      end
   end

   assign run      = run_reg;
   assign level    = lvl_reg;
   assign on_start = start_reg;
   assign on_end   = end_reg;
   assign first    = first_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_start_on_write: assert property (
      cfg_wr && cswt_on_active(cfg.on_sel) |=> on_start && first && level)
      else $error("timer did not start on on-time write");
   a_keep_running: assert property (
      run && !cfg_wr |=> run)
      else $error("timer stopped without a write");
endmodule : cswt_timer

// ===== rtl/cswt_top.sv
`timescale 1ns/1ns
`include "cswt_params.svh"
module cswt_top #(
   parameter int TICK_CYC = `CSWT_TICK_NS / `CSWT_CLK_NS
) (
   // clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         arst_n,
   // operating mode and mode requests
   input  wire cswt_pkg::cswt_mode_e         mode,
   input  wire logic                         sleep_cmd,
   // timer configuration
   input  wire cswt_pkg::cswt_tmr_cfg_s [1:0] tmr_cfg,
   input  wire logic [1:0]                   tmr_cfg_wr,
   input  wire logic [1:0]                   wake_src_en,
   // high-side switches
   input  wire logic [3:0][1:0]              hs_map,
   input  wire cswt_pkg::cswt_hs_fault_s [3:0] hs_fault,
   input  wire logic [3:0]                   hs_uvov_en,
   input  wire logic [3:0]                   hs_dis_clr,
   output logic [3:0]                        high_side_switch,
   output logic [3:0]                        hs_disabled,
   // wake inputs
   input  wire logic [2:0]                   wake_input_pin,
   input  wire logic [2:0][1:0]              wake_sense_sel,
   // status and clears
   input  wire logic [2:0]                   wake_status_a_clr,
   input  wire logic [1:0]                   wake_status_b_clr,
   input  wire logic                         spi_fail_clr,
   output logic [2:0]                        wake_status_a,
   output logic [1:0]                        wake_status_b,
   output logic                              spi_fail,
   // host notification
   output logic                              int_req,
   output logic                              restart_req,
   output logic [4:0]                        wake_source
);
   import cswt_pkg::*;

   localparam int FILT_CYC =
      (`CSWT_FILT_NS + `CSWT_CLK_NS - 1) / `CSWT_CLK_NS;

   // refuse a timebase divider the 16-bit counter cannot hold
   if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_tick_chk
      $error("TICK_CYC out of range");
   end

   // ==========================================================
   // timebase and pin synchronisers
   logic [15:0] div_reg, div_next;
   logic        tick_reg, tick_next;
   logic [2:0]  wk_m_reg, wk_s_reg, wk_prev_reg;

   always_comb begin
      tick_next = (div_reg == 16'(TICK_CYC - 1));
      div_next  = tick_next ? 16'h0000 : div_reg + 16'h0001;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg     <= 16'h0000;
         tick_reg    <= 1'b0;
         wk_m_reg    <= 3'h0;
         wk_s_reg    <= 3'h0;
         wk_prev_reg <= 3'h0;
      end else begin
         div_reg     <= div_next;
         tick_reg    <= tick_next;
         wk_m_reg    <= wake_input_pin;
         wk_s_reg    <= wk_m_reg;
         wk_prev_reg <= wk_s_reg;
      end
   end

   // ==========================================================
   // two period timers
   logic [1:0] t_run, t_lvl, t_start, t_end, t_first;

   for (genvar t = 0; t < 2; t++) begin : g_tmr
      cswt_timer u_tmr (
         .core_clk (core_clk),
         .arst_n   (arst_n),
         .tick     (tick_reg),
         .cfg_wr   (tmr_cfg_wr[t]),
         .cfg      (tmr_cfg[t]),
         .run      (t_run[t]),
         .level    (t_lvl[t]),
         .on_start (t_start[t]),
         .on_end   (t_end[t]),
         .first    (t_first[t])
      );
   end

   // ==========================================================
   // switches, sensing, flags
   logic [3:0]       hs_reg,   hs_next;
   logic [3:0]       dis_reg,  dis_next;
   logic [2:0][10:0] filt_reg, filt_next;
   logic [2:0]       samp_reg, samp_next;
   logic [2:0]       ref_reg,  ref_next;
   logic [2:0]       href_reg, href_next;
   logic [2:0]       wfl_reg,  wfl_next;
   logic [1:0]       tfl_reg,  tfl_next;
   logic             fail_reg, fail_next;
   logic             int_reg,  int_next;
   logic             cwi_reg,  cwi_next;
   logic             rst_reg,  rst_next;
   logic [4:0]       src_reg,  src_next;
   logic [2:0]       wake_evt;
   logic [1:0]       cw_evt;
   logic             act_mode, fs_mode, ns_mode;
   logic [1:0]       sel;
   logic             ti;

   always_comb begin
      act_mode = (mode == CSWT_NORMAL) || (mode == CSWT_STOP) ||
                 (mode == CSWT_SLEEP);
      fs_mode  = (mode == CSWT_FAILSAFE);
      ns_mode  = (mode == CSWT_NORMAL) || (mode == CSWT_STOP);
      sel      = 2'h0;
      ti       = 1'b0;
      // switch fault latch, set wins over clear
      for (int i = 0; i < 4; i++) begin
         dis_next[i] = (dis_reg[i] & ~hs_dis_clr[i]) |
                       (act_mode & (hs_fault[i].oc | hs_fault[i].ot |
                        (hs_fault[i].uv_ov & hs_uvov_en[i])));
         case (hs_map[i])
            `CSWT_MAP_ON: hs_next[i] = 1'b1;
            `CSWT_MAP_T1: hs_next[i] = t_lvl[0] & ~fs_mode;
            `CSWT_MAP_T2: hs_next[i] = t_lvl[1] & ~fs_mode;
            default:      hs_next[i] = 1'b0;
         endcase
         hs_next[i] = hs_next[i] & ~dis_next[i];
      end
      // wake input sensing
      for (int k = 0; k < 3; k++) begin
         sel          = fs_mode ? `CSWT_SNS_STATIC : wake_sense_sel[k];
         ti           = (sel == `CSWT_SNS_T2);
         filt_next[k] = filt_reg[k];
         samp_next[k] = samp_reg[k];
         ref_next[k]  = ref_reg[k];
         href_next[k] = href_reg[k];
         wake_evt[k]  = 1'b0;
         if (sel != `CSWT_SNS_T1 && sel != `CSWT_SNS_T2) begin
            filt_next[k] = 11'h000;
            href_next[k] = 1'b0;
            wake_evt[k]  = wk_s_reg[k] ^ wk_prev_reg[k];
         end else if (t_end[ti]) begin
            filt_next[k] = 11'(FILT_CYC);
            samp_next[k] = wk_s_reg[k];
         end else if (filt_reg[k] != 11'h000) begin
            if (wk_s_reg[k] != samp_reg[k]) begin
               filt_next[k] = 11'h000;
            end else begin
               filt_next[k] = filt_reg[k] - 11'h001;
               if (filt_reg[k] == 11'h001) begin
                  wake_evt[k]  = href_reg[k] & (samp_reg[k] ^ ref_reg[k]);
                  ref_next[k]  = samp_reg[k];
                  href_next[k] = 1'b1;
               end
            end
         end
      end
      // cyclic wake, first start after a write stays quiet
      cw_evt   = wake_src_en & t_start & ~t_first & {2{ns_mode}};
      wfl_next = (wfl_reg & ~wake_status_a_clr) | wake_evt;
      tfl_next = (tfl_reg & ~wake_status_b_clr) | cw_evt;
      cwi_next = |cw_evt;
      int_next = ns_mode & ((|wake_evt) | (|cw_evt));
      rst_next = ((mode == CSWT_SLEEP) & (|wake_evt)) |
                 (sleep_cmd & (|{wfl_reg, tfl_reg}));
      src_next = rst_next ? {tfl_next, wfl_next} : src_reg;
      // on-time longer than period, set wins over clear
      fail_next = fail_reg & ~spi_fail_clr;
      for (int t = 0; t < 2; t++) begin
         if (tmr_cfg_wr[t] && cswt_on_active(tmr_cfg[t].on_sel) &&
             cswt_on_ticks(tmr_cfg[t].on_sel) >
             cswt_per_ticks(tmr_cfg[t].per_sel))
            fail_next = 1'b1;
      end
   end

   // register stage
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_reg   <= 4'h0;
         dis_reg  <= 4'h0;
         filt_reg <= '0;
         samp_reg <= 3'h0;
         ref_reg  <= 3'h0;
         href_reg <= 3'h0;
         wfl_reg  <= 3'h0;
         tfl_reg  <= 2'h0;
         fail_reg <= 1'b0;
         int_reg  <= 1'b0;
         cwi_reg  <= 1'b0;
         rst_reg  <= 1'b0;
         src_reg  <= 5'h00;
      end else begin
         hs_reg   <= hs_next;
         dis_reg  <= dis_next;
         filt_reg <= filt_next;
         samp_reg <= samp_next;
         ref_reg  <= ref_next;
         href_reg <= href_next;
         wfl_reg  <= wfl_next;
         tfl_reg  <= tfl_next;
         fail_reg <= fail_next;
         int_reg  <= int_next;
         cwi_reg  <= cwi_next;
         rst_reg  <= rst_next;
         src_reg  <= src_next;
      end
   end

   assign high_side_switch = hs_reg;
   assign hs_disabled      = dis_reg;
   assign wake_status_a    = wfl_reg;
   assign wake_status_b    = tfl_reg;
   assign spi_fail         = fail_reg;
   assign int_req          = int_reg;
   assign restart_req      = rst_reg;
   assign wake_source      = src_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_fs_hs_off: assert property (
      fs_mode && hs_map[0] == `CSWT_MAP_T1 |=> !high_side_switch[0])
      else $error("timer switch on in fail-safe");
   a_fault_hs_off: assert property (
      act_mode && (hs_fault[0].oc || hs_fault[0].ot)
      |=> hs_disabled[0] && !high_side_switch[0])
      else $error("faulted switch not disabled");
   a_wake_flag: assert property (
      |wake_evt |=> (wake_status_a & $past(wake_evt)) == $past(wake_evt))
      else $error("wake flag not set");
   a_stop_int: assert property (
      mode == CSWT_STOP && |wake_evt |=> int_req && !restart_req)
      else $error("stop wake without interrupt");
   a_sleep_restart: assert property (
      mode == CSWT_SLEEP && |wake_evt |=> restart_req && !int_req)
      else $error("sleep wake without restart");
   a_sleep_flags: assert property (
      sleep_cmd && |{wake_status_b, wake_status_a}
      |=> restart_req && |wake_source)
      else $error("sleep with flags did not restart");
   a_first_quiet: assert property (
      t_start[0] && t_first[0] && !t_start[1] |=> !cwi_reg)
      else $error("interrupt on first on-time start");
   a_cyc_wake: assert property (
      ns_mode && wake_src_en[0] && t_start[0] && !t_first[0]
      |=> int_req && wake_status_b[0])
      else $error("cyclic wake interrupt missing");
   a_spi_fail: assert property (
      tmr_cfg_wr[1] && tmr_cfg[1].on_sel == 3'h4 && tmr_cfg[1].per_sel == 3'h0
      |=> spi_fail)
      else $error("on-time above period not flagged");
   a_filter_abort: assert property (
      filt_reg[0] > 11'h001 && wk_s_reg[0] != samp_reg[0] &&
      !t_end[0] && !t_end[1]
      |=> filt_reg[0] == 11'h000 ##1
          (!wake_status_a[0] || $past(wake_status_a[0], 2)))
      else $error("unstable sample not rejected");
endmodule : cswt_top

// ===== verif/cswt_host.sv
`timescale 1ns/1ns
// ==========================================================
// host controller model: sleep requests and status clears
module cswt_host (
   // clock
   input  wire logic core_clk,
   // requests to the device
   output logic       sleep_cmd,
   output logic [2:0] wake_status_a_clr,
   output logic [1:0] wake_status_b_clr,
   output logic       spi_fail_clr
);
   // request lines idle from time zero
   initial begin
      sleep_cmd         = 1'b0;
      wake_status_a_clr = 3'h0;
      wake_status_b_clr = 2'h0;
      spi_fail_clr      = 1'b0;
   end

   // one-cycle sleep command
   task automatic sleep_req();
      @(negedge core_clk);
      sleep_cmd = 1'b1;
      @(negedge core_clk);
      sleep_cmd = 1'b0;
   endtask : sleep_req

   // clear every flag, promptly or after a delay
   task automatic clear_all(input int dly);
      repeat (dly) @(negedge core_clk);
      @(negedge core_clk);
      wake_status_a_clr = 3'h7;
      wake_status_b_clr = 2'h3;
      spi_fail_clr      = 1'b1;
      @(negedge core_clk);
      wake_status_a_clr = 3'h0;
      wake_status_b_clr = 2'h0;
      spi_fail_clr      = 1'b0;
   endtask : clear_all
endmodule : cswt_host

// ===== verif/cswt_top_tb_top.sv
`timescale 1ns/1ns
module cswt_top_tb_top;
   import cswt_pkg::*;
   // ==========================================================
   // signals
   logic                 core_clk, arst_n, sleep_cmd, spi_fail_clr;
   logic                 spi_fail, int_req, restart_req;
   cswt_mode_e           mode;
   cswt_tmr_cfg_s [1:0]  tmr_cfg;
   logic [1:0]           tmr_cfg_wr, wake_src_en, wake_status_b_clr;
   logic [3:0][1:0]      hs_map;
   cswt_hs_fault_s [3:0] hs_fault;
   logic [3:0]           hs_uvov_en, hs_dis_clr, high_side_switch;
   logic [3:0]           hs_disabled;
   logic [2:0]           wake_input_pin, wake_status_a_clr, wake_status_a;
   logic [2:0][1:0]      wake_sense_sel;
   logic [1:0]           wake_status_b;
   logic [4:0]           wake_source;
   int                   n_mismatch, checks, n;

   // ==========================================================
   // design and host model
   cswt_top #(.TICK_CYC(2)) i_cswt_top (
      .core_clk(core_clk), .arst_n(arst_n), .mode(mode),
      .sleep_cmd(sleep_cmd), .tmr_cfg(tmr_cfg), .tmr_cfg_wr(tmr_cfg_wr),
      .wake_src_en(wake_src_en), .hs_map(hs_map), .hs_fault(hs_fault),
      .hs_uvov_en(hs_uvov_en), .hs_dis_clr(hs_dis_clr),
      .high_side_switch(high_side_switch), .hs_disabled(hs_disabled),
      .wake_input_pin(wake_input_pin), .wake_sense_sel(wake_sense_sel),
      .wake_status_a_clr(wake_status_a_clr),
      .wake_status_b_clr(wake_status_b_clr),
      .spi_fail_clr(spi_fail_clr), .wake_status_a(wake_status_a),
      .wake_status_b(wake_status_b), .spi_fail(spi_fail),
      .int_req(int_req), .restart_req(restart_req),
      .wake_source(wake_source)
   );
   cswt_host i_cswt_host (
      .core_clk(core_clk), .sleep_cmd(sleep_cmd),
      .wake_status_a_clr(wake_status_a_clr),
      .wake_status_b_clr(wake_status_b_clr), .spi_fail_clr(spi_fail_clr)
   );

   // ==========================================================
   // helpers
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // write one timer configuration
   task automatic cfg(input int t, input logic [2:0] per, on);
      @(negedge core_clk);
      tmr_cfg[t]    = {per, on};
      tmr_cfg_wr[t] = 1'b1;
      @(negedge core_clk);
      tmr_cfg_wr = 2'h0;
   endtask : cfg

   // bounded wait for int, restart or switch 0; n is -1 if unseen
   task automatic wait_hi(input int sel, max, input bit must,
                          output int n);
      logic s;
      n = -1;
      for (int i = 1; i <= max && n < 0; i++) begin
         @(negedge core_clk);
         s = sel == 0 ? int_req : sel == 1 ? restart_req
                                           : high_side_switch[0];
         if (s === 1'b1) n = i;
      end
      if (must && n < 0) begin
         chk("wait bound", 1, 0);
         summarize();
      end
   endtask : wait_hi

   // count cycles where a switch leaves a level
   task automatic hold(input int idx, input logic lvl, input int cyc,
                       output int n);
      n = 0;
      repeat (cyc) begin
         @(negedge core_clk);
         n += (high_side_switch[idx] !== lvl);
      end
   endtask : hold

   // ==========================================================
   // clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ==========================================================
   // tests
   initial begin
      n_mismatch = 0;
      checks = 0;
      arst_n = 1'b0;
      mode = CSWT_NORMAL;
      tmr_cfg = '0;
      tmr_cfg_wr = 2'h0;
      wake_src_en = 2'h0;
      hs_map = {2'h0, 2'h0, 2'h3, 2'h2};
      hs_fault = '0;
      hs_uvov_en = 4'h0;
      hs_dis_clr = 4'h0;
      wake_input_pin = 3'h0;
      wake_sense_sel = '0;
      repeat (3) @(negedge core_clk);
      arst_n = 1'b1;
      chk("reset outputs", 0, {high_side_switch, hs_disabled, spi_fail,
                               wake_status_a, wake_status_b});
      // timer pulses a mapped switch, periods 10 ms and 20 ms
      for (int p = 0; p < 2; p++) begin
         cfg(0, 3'(p), 3'h0);
         repeat (2) @(negedge core_clk);
         chk("switch on", 1, high_side_switch[0]);
         repeat (30) @(negedge core_clk);
         chk("switch off", 0, high_side_switch[0]);
         wait_hi(2, 5000, 1, n);
         // first period may lose one cycle to the free-running timebase
         chk("period", 1, (n + 31 - 2000 * (p + 1)) inside {-1, 0});
      end
      $display("test timer pulse done");
      // static high then low on the second timer's switch
      cfg(1, 3'h0, 3'h6);
      repeat (2) @(negedge core_clk);
      hold(1, 1'b1, 2100, n);
      chk("static high", 0, n);
      cfg(1, 3'h0, 3'h5);
      hold(1, 1'b0, 10, n);
      chk("static low", 1, n < 3);
      // on-time equal to period, then longer
      cfg(1, 3'h0, 3'h3);
      @(negedge core_clk);
      chk("equal on-time", 0, spi_fail);
      cfg(1, 3'h0, 3'h4);
      @(negedge core_clk);
      chk("long on-time", 1, spi_fail);
      cfg(1, 3'h0, 3'h5);
      i_cswt_host.clear_all(3);
      chk("fail cleared", 0, spi_fail);
      $display("test static and failure done");
      // cyclic wake: disarm, enable source, then start
      cfg(0, 3'h0, 3'h5);
      wake_src_en = 2'h1;
      cfg(0, 3'h0, 3'h0);
      wait_hi(0, 1990, 0, n);
      chk("first start silent", 0, n > 0);
      wait_hi(0, 100, 1, n);
      chk("timer flag", 2'h1, wake_status_b);
      wake_src_en = 2'h0;
      // faults: overcurrent disables, masked uv/ov does not
      hs_fault[0].oc = 1'b1;
      hs_fault[1].uv_ov = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("fault disable", 4'h1, hs_disabled);
      chk("fault switch", 0, high_side_switch[0]);
      hs_uvov_en = 4'h2;
      @(negedge core_clk);
      chk("uv/ov enabled", 4'h3, hs_disabled);
      hs_fault = '0;
      hs_dis_clr = 4'hf;
      @(negedge core_clk);
      hs_dis_clr = 4'h0;
      wait_hi(2, 2100, 1, n);
      $display("test cyclic wake and faults done");
      // sleep with a flag still set, then with flags cleared
      // restart stands one cycle: watch it while the command goes out
      fork
         i_cswt_host.sleep_req();
         wait_hi(1, 3, 1, n);
      join
      chk("wake source", 5'h08, wake_source);
      i_cswt_host.clear_all(0);
      fork
         i_cswt_host.sleep_req();
         wait_hi(1, 5, 0, n);
      join
      chk("no restart", 0, n > 0);
      $display("test sleep request done");
      // cyclic sense armed in normal mode, then stop
      wake_sense_sel[0] = 2'h1;
      cfg(0, 3'h1, 3'h0);
      mode = CSWT_STOP;
      wait_hi(0, 3000, 0, n);
      chk("reference only", 0, n > 0);
      wake_input_pin[0] = 1'b1;
      wait_hi(0, 4000, 1, n);
      chk("sense flag", 3'h1, wake_status_a);
      i_cswt_host.clear_all(0);
      mode = CSWT_SLEEP;
      wake_input_pin[0] = 1'b0;
      // a glitch inside the filter throws that sample away
      wait_hi(2, 4100, 1, n);
      repeat (200) @(negedge core_clk);
      wake_input_pin[0] = 1'b1;
      @(negedge core_clk);
      wake_input_pin[0] = 1'b0;
      wait_hi(1, 2000, 0, n);
      chk("glitch rejected", 0, n > 0);
      wait_hi(1, 4200, 1, n);
      $display("test cyclic sense done");
      // fail-safe: switch forced off, input back to static
      mode = CSWT_FAILSAFE;
      hold(0, 1'b0, 4100, n);
      chk("failsafe switch", 0, n);
      i_cswt_host.clear_all(0);
      wake_input_pin[0] = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("static sensing", 3'h1, wake_status_a);
      $display("test fail-safe done");
      summarize();
   end
endmodule : cswt_top_tb_top
